// ==== hdl/port_defs.svh ====
/*
 * constants of the serial port register block: offsets, bit labels,
 * reset values and widths.
 * assumes: included by bare name from each design file that needs them.
 */
`ifndef PORT_DEFS_SVH
`define PORT_DEFS_SVH

// ==========================================================
// register offsets, byte addresses from port_base
// ==========================================================
`define OFS_W 4
`define OFS_RX_QUEUE 4'h0
`define OFS_TX_QUEUE 4'h4
`define OFS_STATUS 4'h8
`define OFS_CONTROL 4'hc

// ==========================================================
// bit labels, big-endian: label 0 is the msb, label 31 the lsb
// ==========================================================
`define WORD_W 32
`define LBL(n) (31 - (n))
`define ST_PARITY_FAULT 24
`define ST_FRAME_FAULT 25
`define ST_OVERRUN_FAULT 26
`define ST_IRQ_ENABLE_MIRROR 27
`define ST_TX_FULL 28
`define ST_TX_EMPTY 29
`define ST_RX_FULL 30
`define ST_RX_VALID 31
`define CT_IRQ_ENABLE_CTL 27
`define CT_RX_FLUSH 30
`define CT_TX_FLUSH 31

// ==========================================================
// reset values and sizes
// ==========================================================
`define RST_WORD 32'h0000_0000
`define RST_BIT 1'b0
`define SET_BIT 1'b1
`define DEF_DATA_BITS 8
`define DEF_DEPTH_LOG2 4
`define FAULT_COUNT 3

`endif

// ==== hdl/port_pkg.sv ====
/*
 * types shared by the serial port register block.
 * assumes: compiled before every module that imports it.
 */
package port_pkg;

    // ==========================================================
    // types
    // ==========================================================
    // which register a bus access lands on
    typedef enum logic [2:0] {
        SEL_RX,
        SEL_TX,
        SEL_STATUS,
        SEL_CONTROL,
        SEL_NONE
    } reg_sel_t;

    // one bus data word
    typedef logic [31:0] word_t;

endpackage

// ==== hdl/char_queue.sv ====
/*
 * character queue with flush: push, pop, head, empty and full.
 * assumes: single clock, synchronous active-low reset; callers never
 * rely on a push into a full queue or a pop from an empty one.
 */
`timescale 1ns/10ps
`include "port_defs.svh"

module char_queue import port_pkg::*; #(
    parameter int WIDTH = `DEF_DATA_BITS,
    parameter int DEPTH_LOG2 = `DEF_DEPTH_LOG2
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // control
    input wire logic flush_i,
    input wire logic push_i,
    input wire logic pop_i,
    // data
    input wire logic [WIDTH-1:0] wdata_i,
    output logic [WIDTH-1:0] head_o,
    // state
    output logic empty_o,
    output logic full_o
);

    localparam int DEPTH = 1 << DEPTH_LOG2;

    // ==========================================================
    // storage and pointers
    // ==========================================================
    logic [WIDTH-1:0] mem [DEPTH];              // character store
    logic [DEPTH_LOG2-1:0] wr_q, wr_d;          // next free slot
    logic [DEPTH_LOG2-1:0] rd_q, rd_d;          // oldest character
    logic [DEPTH_LOG2:0] cnt_q, cnt_d;          // characters held
    logic do_push;
    logic do_pop;

    // pushes into a full queue and pops from an empty one are dropped
    assign do_push = push_i && !full_o;
    assign do_pop = pop_i && !empty_o;
    assign head_o = mem[rd_q];
    assign empty_o = (cnt_q == '0);
    assign full_o = cnt_q[DEPTH_LOG2];

    // next pointers; a flush wins over anything in the same cycle
    always_comb begin
        wr_d = wr_q;
        rd_d = rd_q;
        cnt_d = cnt_q;
        if (flush_i) begin
            wr_d = '0;
            rd_d = '0;
            cnt_d = '0;
        end else begin
            if (do_push) begin
                wr_d = wr_q + 1'b1;
            end
            if (do_pop) begin
                rd_d = rd_q + 1'b1;
            end
            if (do_push && !do_pop) begin
                cnt_d = cnt_q + 1'b1;
            end else if (do_pop && !do_push) begin
                cnt_d = cnt_q - 1'b1;
            end
        end
    end

    // pointer registers
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    // the store itself has no reset; only the pointers define content
    always_ff @(posedge clk_i) begin
        if (do_push && !flush_i) begin
            mem[wr_q] <= wdata_i;
        end
    end

endmodule

// ==== hdl/sticky_flags.sv ====
/*
 * a row of sticky flags: set by hardware events, all cleared together.
 * assumes: single clock, synchronous active-low reset.
 */
`timescale 1ns/10ps
`include "port_defs.svh"

module sticky_flags import port_pkg::*; #(
    parameter int N = `FAULT_COUNT
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // events and clear
    input wire logic [N-1:0] set_i,
    input wire logic clr_i,
    // held flags
    output logic [N-1:0] flags_o
);

    // ==========================================================
    // one flag per bit
    // ==========================================================
    for (genvar i = 0; i < N; i++) begin : g_flag
        logic q;
        logic d;
        // a set in the clearing cycle wins, so no event is ever lost
        always_comb begin
            d = set_i[i] | (q & ~clr_i);
        end
        always_ff @(posedge clk_i) begin
            if (!rst_b_i) begin
                q <= `RST_BIT;
            end else begin
                q <= d;
            end
        end
        assign flags_o[i] = q;
    end

endmodule

// ==== hdl/serial_port_regs.sv ====
/*
 * register interface and interrupt of a small serial port: receive
 * queue, transmit queue, status word, control word, one interrupt.
 * assumes: a host master that raises sel_i for one access and holds it
 * until ack_o, a serial transmitter that takes characters with a
 * valid/take handshake, and a serial receiver that strobes each
 * character with its fault indications; all on clk_i.
 */
`timescale 1ns/10ps
`include "port_defs.svh"

// How it works
// (R1) status 27 mirrors interrupt enable, resets 0
// (R2) status 28 set when transmit queue full
// (R3) status 29 set when transmit queue and stage empty
// (R4) status 30 set when receive queue full
// (R5) status 31 set when receive data waiting
// (R6) control 27 gates interrupt, resets 0
// (R7) control 30 written one flushes receive queue
// (R8) control 31 written one flushes transmit queue
// (R9) read offset 0 pops oldest received character
// (R10) write offset 4 pushes transmit character
// (R11) read offset 8 returns status word
// (R12) write offset 12 updates control word
// (R13) interrupt held while enabled and receive data waits
// (R14) transmit queue draining gives one-cycle interrupt
// (R15) status 24 latches parity fault, read clears
// (R16) status 25 latches framing fault, character dropped
// (R17) status 26 latches overrun, character dropped
// (R18) interrupt is enabled OR of both causes
// (R19) wrong-direction accesses change no state
module serial_port_regs import port_pkg::*; #(
    parameter int DATA_BITS = `DEF_DATA_BITS,
    parameter int DEPTH_LOG2 = `DEF_DEPTH_LOG2,
    parameter bit USE_PARITY = 1'b0
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // host register port
    input wire logic sel_i,
    input wire logic rnw_i,
    input wire logic [`OFS_W-1:0] addr_i,
    input wire logic [`WORD_W-1:0] wdata_i,
    output logic [`WORD_W-1:0] rdata_o,
    output logic ack_o,
    // toward the serial transmitter
    output logic [DATA_BITS-1:0] tx_char_o,
    output logic tx_valid_o,
    input wire logic tx_take_i,
    // from the serial receiver
    input wire logic [DATA_BITS-1:0] rx_char_i,
    input wire logic rx_strobe_i,
    input wire logic rx_parity_err_i,
    input wire logic rx_frame_err_i,
    // interrupt
    output logic irq_o
);

    // ==========================================================
    // declarations
    // ==========================================================
    // bus answer registers
    logic [`WORD_W-1:0] rdata_q, rdata_d;       // read data held with ack
    logic ack_q, ack_d;                         // one-cycle answer
    // control state
    logic irq_enable_ctl_q, irq_enable_ctl_d;   // interrupt gate
    // transmit output stage, so the serial side sees flops only
    logic [DATA_BITS-1:0] tx_char_q, tx_char_d;
    logic tx_valid_q, tx_valid_d;
    // interrupt path
    logic tx_idle_prev_q, tx_idle_prev_d;       // idle last cycle
    logic irq_q, irq_d;
    // decoded access
    logic take;                                 // request taken now
    reg_sel_t sel;                              // register addressed
    logic rx_pop;
    logic tx_push;
    logic rx_flush;
    logic tx_flush;
    logic status_read;
    // queue signals
    logic [DATA_BITS-1:0] rx_head;
    logic [DATA_BITS-1:0] tx_head;
    logic rx_empty;
    logic rx_full;
    logic tx_empty;
    logic tx_full;
    logic rx_push;
    logic tx_pop;
    logic tx_idle;                              // queue and stage empty
    logic tx_drained;                           // idle just reached
    // faults
    logic [`FAULT_COUNT-1:0] fault_set;
    logic [`FAULT_COUNT-1:0] faults;            // parity, frame, overrun
    logic [`WORD_W-1:0] status_word;

    // ==========================================================
    // address decode
    // ==========================================================
    // a request is taken only when no answer is out, so a held select
    // is seen once per access
    assign take = sel_i && !ack_q;

    // map the offset to a register
    always_comb begin
        case (addr_i)
            `OFS_RX_QUEUE: sel = SEL_RX;
            `OFS_TX_QUEUE: sel = SEL_TX;
            `OFS_STATUS: sel = SEL_STATUS;
            `OFS_CONTROL: sel = SEL_CONTROL;
            default: sel = SEL_NONE;
        endcase
    end

    // side effects only in the direction each register allows
    assign rx_pop = take && rnw_i && (sel == SEL_RX) && !rx_empty;      // see (R9) (R19)
    assign tx_push = take && !rnw_i && (sel == SEL_TX);                 // see (R10) (R19)
    assign status_read = take && rnw_i && (sel == SEL_STATUS);          // see (R11) (R19)
    // flush strobes act only on a control write with the bit at one
    assign rx_flush = take && !rnw_i && (sel == SEL_CONTROL)
                      && wdata_i[`LBL(`CT_RX_FLUSH)];                   // see (R7)
    assign tx_flush = take && !rnw_i && (sel == SEL_CONTROL)
                      && wdata_i[`LBL(`CT_TX_FLUSH)];                   // see (R8)

    // ==========================================================
    // receive side
    // ==========================================================
    // a framed-wrong character never reaches the queue; a full queue
    // turns the character into an overrun instead
    assign rx_push = rx_strobe_i && !rx_frame_err_i && !rx_full;        // see (R16) (R17)

    // fault events: parity only when parity handling is built in
    assign fault_set[0] = USE_PARITY && rx_strobe_i && !rx_frame_err_i
                          && rx_parity_err_i;                           // see (R15)
    assign fault_set[1] = rx_strobe_i && rx_frame_err_i;                // see (R16)
    assign fault_set[2] = rx_strobe_i && !rx_frame_err_i && rx_full;    // see (R17)

    char_queue #(
        .WIDTH(DATA_BITS),
        .DEPTH_LOG2(DEPTH_LOG2)
    ) u_rx_queue (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .flush_i(rx_flush),
        .push_i(rx_push),
        .pop_i(rx_pop),
        .wdata_i(rx_char_i),
        .head_o(rx_head),
        .empty_o(rx_empty),
        .full_o(rx_full)
    );

    // faults are cleared by reading the status word
    sticky_flags #(
        .N(`FAULT_COUNT)
    ) u_faults (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .set_i(fault_set),
        .clr_i(status_read),                                            // see (R15)
        .flags_o(faults)
    );

    // ==========================================================
    // transmit side
    // ==========================================================
    // outside a flush, the stage reloads whenever it is empty or being taken
    assign tx_pop = !tx_empty && (!tx_valid_q || tx_take_i) && !tx_flush;
    assign tx_idle = tx_empty && !tx_valid_q;
    assign tx_drained = tx_idle && !tx_idle_prev_q;

    char_queue #(
        .WIDTH(DATA_BITS),
        .DEPTH_LOG2(DEPTH_LOG2)
    ) u_tx_queue (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .flush_i(tx_flush),
        .push_i(tx_push),
        .pop_i(tx_pop),
        .wdata_i(wdata_i[DATA_BITS-1:0]),
        .head_o(tx_head),
        .empty_o(tx_empty),
        .full_o(tx_full)
    );

    // next transmit stage
    always_comb begin
        tx_char_d = tx_char_q;
        tx_valid_d = tx_valid_q;
        if (tx_flush) begin
            // a flush also withdraws the character on offer
            tx_valid_d = `RST_BIT;                                      // see (R8)
        end else if (tx_pop) begin
            tx_char_d = tx_head;
            tx_valid_d = `SET_BIT;
        end else if (tx_take_i) begin
            tx_valid_d = `RST_BIT;
        end
    end

    // ==========================================================
    // status word
    // ==========================================================
    // reserved labels read as zero
    always_comb begin
        status_word = `RST_WORD;
        status_word[`LBL(`ST_PARITY_FAULT)] = faults[0];                // see (R15)
        status_word[`LBL(`ST_FRAME_FAULT)] = faults[1];                 // see (R16)
        status_word[`LBL(`ST_OVERRUN_FAULT)] = faults[2];               // see (R17)
        status_word[`LBL(`ST_IRQ_ENABLE_MIRROR)] = irq_enable_ctl_q;    // see (R1)
        status_word[`LBL(`ST_TX_FULL)] = tx_full;                       // see (R2)
        // the character on offer to the transmitter still counts
        status_word[`LBL(`ST_TX_EMPTY)] = tx_idle;                      // see (R3)
        status_word[`LBL(`ST_RX_FULL)] = rx_full;                       // see (R4)
        status_word[`LBL(`ST_RX_VALID)] = !rx_empty;                    // see (R5)
    end

    // ==========================================================
    // bus answer and control word
    // ==========================================================
    // next answer: write-only and unmapped offsets read as zero
    always_comb begin
        rdata_d = `RST_WORD;
        ack_d = take;
        irq_enable_ctl_d = irq_enable_ctl_q;
        if (take && rnw_i) begin
            case (sel)
                SEL_RX: begin
                    // an empty queue answers zero and pops nothing
                    if (!rx_empty) begin
                        rdata_d[DATA_BITS-1:0] = rx_head;               // see (R9)
                    end
                end
                SEL_STATUS: begin
                    rdata_d = status_word;                              // see (R11)
                end
                default: begin
                    rdata_d = `RST_WORD;                                // see (R19)
                end
            endcase
        end else if (take && (sel == SEL_CONTROL)) begin
            irq_enable_ctl_d = wdata_i[`LBL(`CT_IRQ_ENABLE_CTL)];      // see (R12) (R6)
        end
    end

    // ==========================================================
    // interrupt
    // ==========================================================
    // the level cause holds while data waits; the drain cause lasts one
    // cycle because the previous-idle flag catches up next edge
    always_comb begin
        tx_idle_prev_d = tx_idle;
        irq_d = irq_enable_ctl_q && (!rx_empty || tx_drained);          // see (R13) (R14) (R18) (R6)
    end

    // ==========================================================
    // registers
    // ==========================================================
    // every state register of the top sits here
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            rdata_q <= `RST_WORD;
            ack_q <= `RST_BIT;
            irq_enable_ctl_q <= `RST_BIT;                               // see (R1) (R6)
            tx_char_q <= '0;
            tx_valid_q <= `RST_BIT;
            // idle at reset, so leaving reset raises no drain event
            tx_idle_prev_q <= `SET_BIT;
            irq_q <= `RST_BIT;
        end else begin
            rdata_q <= rdata_d;
            ack_q <= ack_d;
            irq_enable_ctl_q <= irq_enable_ctl_d;
            tx_char_q <= tx_char_d;
            tx_valid_q <= tx_valid_d;
            tx_idle_prev_q <= tx_idle_prev_d;
            irq_q <= irq_d;
        end
    end

    // ==========================================================
    // outputs
    // ==========================================================
    // all straight from flops
    assign rdata_o = rdata_q;
    assign ack_o = ack_q;
    assign tx_char_o = tx_char_q;
    assign tx_valid_o = tx_valid_q;
    assign irq_o = irq_q;

endmodule

// ==== verification/serial_port_regs_monitor.sv ====
/*
 * checker of the serial port registers, from its ports only.
 * assumes: bound into serial_port_regs; one clock, low reset.
 */
`timescale 1ns/10ps

module serial_port_regs_monitor #(
    parameter int DATA_BITS = 8
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // host register port
    input wire logic sel_i,
    input wire logic rnw_i,
    input wire logic [3:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic [31:0] rdata_o,
    input wire logic ack_o,
    // serial side
    input wire logic [DATA_BITS-1:0] tx_char_o,
    input wire logic tx_valid_o,
    input wire logic tx_take_i,
    input wire logic [DATA_BITS-1:0] rx_char_i,
    input wire logic rx_strobe_i,
    input wire logic rx_parity_err_i,
    input wire logic rx_frame_err_i,
    input wire logic irq_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    // ====================
    // helper logic
    logic take; // request taken
    logic ctl_wr; // control write taken
    logic tx_wr; // transmit push taken
    logic st_rd; // status read taken
    logic [DATA_BITS-1:0] wchar; // write character
    logic en_q; // enable shadow
    assign take = sel_i && !ack_o;
    assign ctl_wr = take && !rnw_i && addr_i == 4'hc;
    assign tx_wr = take && !rnw_i && addr_i == 4'h4;
    assign st_rd = take && rnw_i && addr_i == 4'h8;
    assign wchar = wdata_i[DATA_BITS-1:0];
    // shadow tracks control writes
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            en_q <= 1'b0;
        end else if (ctl_wr) begin
            en_q <= wdata_i[4];
        end
    end

    // ====================
    // sequences
    // last character taken, nothing behind
    sequence drain_s;
        tx_valid_o && tx_take_i && en_q && !ctl_wr && !tx_wr ##1 !tx_valid_o && !ctl_wr;
    endsequence
    // good character while enabled
    sequence rx_arrive_s;
        rx_strobe_i && !rx_frame_err_i && en_q && !ctl_wr ##1 !ctl_wr;
    endsequence

    // ====================
    // assertions
    ack_timing_a: assert property (take |=> ack_o)
        else $error("ack missing");
    ack_single_a: assert property (ack_o |=> !ack_o)
        else $error("ack too long");
    rdata_idle_a: assert property (!ack_o |-> rdata_o == 32'h0)
        else $error("stray read data");
    enable_mirror_a: assert property (st_rd |=> rdata_o[4] == $past(en_q))
        else $error("enable mirror wrong");
    reserved_zero_a: assert property (st_rd |=> rdata_o[31:7] == 25'h0)
        else $error("reserved bits set");
    wrong_way_a: assert property (take && rnw_i && addr_i inside {4'h4, 4'hc}
        |=> rdata_o == 32'h0)
        else $error("write-only location read nonzero");
    irq_mask_a: assert property (!$past(en_q) |-> !irq_o)
        else $error("interrupt while disabled");
    tx_hold_a: assert property (tx_valid_o && !tx_take_i && !ctl_wr
        |=> tx_valid_o && $stable(tx_char_o))
        else $error("offer changed");
    tx_push_a: assert property (tx_wr && !tx_valid_o ##1 !ctl_wr
        |=> tx_valid_o && tx_char_o == $past(wchar, 2))
        else $error("char not offered");
    rx_irq_a: assert property (rx_arrive_s |=> irq_o)
        else $error("no rx interrupt");
    tx_drain_a: assert property (drain_s |=> irq_o)
        else $error("no drain interrupt");
endmodule

bind serial_port_regs serial_port_regs_monitor #(.DATA_BITS(DATA_BITS)) mon_inst (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .sel_i(sel_i), .rnw_i(rnw_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .ack_o(ack_o),
    .tx_char_o(tx_char_o), .tx_valid_o(tx_valid_o), .tx_take_i(tx_take_i),
    .rx_char_i(rx_char_i), .rx_strobe_i(rx_strobe_i),
    .rx_parity_err_i(rx_parity_err_i), .rx_frame_err_i(rx_frame_err_i), .irq_o(irq_o));

// ==== verification/char_link_model.sv ====
/*
 * serial-side partner: takes offered characters, strobes received ones.
 * assumes: the bench calls send() and drives stall_i at falling edges.
 */
`timescale 1ns/10ps

module char_link_model (
    // clock
    input wire logic clk_i,
    // transmitter side
    input wire logic [7:0] tx_char_i,
    input wire logic tx_valid_i,
    input wire logic stall_i,
    output logic tx_take_o,
    // receiver side
    output logic [7:0] rx_char_o,
    output logic rx_strobe_o,
    output logic rx_parity_err_o,
    output logic rx_frame_err_o
);
    logic [7:0] got[$]; // characters taken, oldest first

    initial begin
        tx_take_o = 1'b0;
        rx_char_o = 8'h5a;
        rx_strobe_o = 1'b0;
        rx_parity_err_o = 1'b0;
        rx_frame_err_o = 1'b0;
    end

    // take whenever offered unless stalled
    always @(negedge clk_i) begin
        tx_take_o <= tx_valid_i && !stall_i;
    end

    // log at the edge where the take is sampled
    always @(posedge clk_i) begin
        if (tx_valid_i && tx_take_o) begin
            got.push_back(tx_char_i);
        end
    end

    // one-cycle strobe; data flips after it
    task automatic send(input logic [7:0] c, input logic fe);
        @(negedge clk_i);
        rx_char_o = c;
        rx_frame_err_o = fe;
        rx_strobe_o = 1'b1;
        @(negedge clk_i);
        rx_strobe_o = 1'b0;
        rx_frame_err_o = 1'b0;
        rx_char_o = ~c;
    endtask
endmodule

// ==== verification/tb.sv ====
/*
 * self-checking bench of the serial port register block.
 * assumes: char_link_model stands on the serial side; 40 MHz clock.
 */
`timescale 1ns/10ps

module tb;
    // ====================
    // signals
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic sel_i = 1'b0;
    logic rnw_i = 1'b0;
    logic [3:0] addr_i = 4'h0;
    logic [31:0] wdata_i = 32'h0;
    logic stall = 1'b1; // transmitter holds off takes
    logic [31:0] rdata_o;
    logic ack_o, tx_valid_o, tx_take_i, rx_strobe_i, rx_pe, rx_fe, irq_o;
    logic [7:0] tx_char_o, rx_char_i;
    int failures = 0;
    int checked = 0;
    int cyc = 0;
    int k;

    always #12.5 clk_i = ~clk_i;

    serial_port_regs serial_port_regs_inst (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .sel_i(sel_i), .rnw_i(rnw_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .ack_o(ack_o),
        .tx_char_o(tx_char_o), .tx_valid_o(tx_valid_o), .tx_take_i(tx_take_i),
        .rx_char_i(rx_char_i), .rx_strobe_i(rx_strobe_i),
        .rx_parity_err_i(rx_pe), .rx_frame_err_i(rx_fe), .irq_o(irq_o));

    char_link_model char_link_model_inst (
        .clk_i(clk_i), .tx_char_i(tx_char_o), .tx_valid_i(tx_valid_o),
        .stall_i(stall), .tx_take_o(tx_take_i), .rx_char_o(rx_char_i),
        .rx_strobe_o(rx_strobe_i), .rx_parity_err_o(rx_pe), .rx_frame_err_o(rx_fe));

    // ====================
    // tasks
    task automatic summarize();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // one access; ack and data looked at mid-cycle, sel dropped in the ack cycle
    task automatic acc(input logic r, input logic [3:0] a, input logic [31:0] d,
                       input string nm);
        int n;
        n = 0;
        @(negedge clk_i);
        sel_i = 1'b1;
        rnw_i = r;
        addr_i = a;
        wdata_i = d;
        do begin
            @(negedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 8);
        sel_i = 1'b0;
        if (n >= 8) chk("ack", 32'h1, 32'h0);
        if (r) chk(nm, d, rdata_o);
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        acc(1'b0, a, d, "");
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] exp, input string nm);
        acc(1'b1, a, exp, nm);
    endtask

    // ====================
    // hang guard, far above the few hundred cycles needed
    always @(posedge clk_i) begin
        cyc++;
        if (cyc > 20000) begin
            failures++;
            summarize();
        end
    end

    // ====================
    // tests
    initial begin
        repeat (5) @(negedge clk_i);
        rst_b_i = 1'b1;
        rd(4'h8, 32'h04, "status after reset");
        chk("irq after reset", 32'h0, irq_o);
        $display("test reset done");
        // stalled: one in stage, sixteen queued, one dropped
        for (int i = 0; i < 18; i++) wr(4'h4, 32'ha0 + i);
        rd(4'h8, 32'h08, "status tx full");
        wr(4'hc, 32'h10);
        stall = 1'b0;
        k = 0;
        repeat (60) begin
            @(negedge clk_i);
            if (irq_o === 1'b1) k++;
        end
        chk("drain irq cycles", 32'd1, k);
        rd(4'h8, 32'h14, "status tx empty");
        chk("taken count", 32'd17, char_link_model_inst.got.size());
        for (int i = 0; i < 17; i++) chk("taken char", 32'ha0 + i, char_link_model_inst.got[i]);
        $display("test transmit done");
        // interrupt level holds until the queue is read empty
        for (int i = 1; i < 4; i++) char_link_model_inst.send(8'h30 + i, 1'b0);
        repeat (3) @(negedge clk_i);
        chk("irq rx level", 32'h1, irq_o);
        rd(4'h8, 32'h15, "status rx valid");
        rd(4'h0, 32'h31, "rx char 1");
        rd(4'h0, 32'h32, "rx char 2");
        chk("irq one left", 32'h1, irq_o);
        rd(4'h0, 32'h33, "rx char 3");
        repeat (2) @(negedge clk_i);
        chk("irq rx empty", 32'h0, irq_o);
        rd(4'h0, 32'h0, "rx empty read");
        $display("test receive done");
        // framed character dropped, then overrun
        char_link_model_inst.send(8'h55, 1'b1);
        for (int i = 0; i < 17; i++) char_link_model_inst.send(8'h40 + i, 1'b0);
        rd(4'h8, 32'h77, "status faults");
        rd(4'h8, 32'h17, "status faults cleared");
        rd(4'h0, 32'h40, "rx oldest");
        wr(4'hc, 32'h12);
        rd(4'h8, 32'h14, "status rx flushed");
        repeat (2) @(negedge clk_i);
        chk("irq after flush", 32'h0, irq_o);
        $display("test faults done");
        // wrong-way and unmapped accesses change nothing
        wr(4'h0, 32'hff);
        wr(4'h8, 32'hff);
        rd(4'h4, 32'h0, "read tx location");
        rd(4'hc, 32'h0, "read control");
        rd(4'h2, 32'h0, "unmapped read");
        rd(4'h8, 32'h14, "status unchanged");
        // flush with disable: no interrupt follows
        stall = 1'b1;
        wr(4'h4, 32'h61);
        wr(4'h4, 32'h62);
        rd(4'h8, 32'h10, "status tx pending");
        wr(4'hc, 32'h01);
        repeat (3) @(negedge clk_i);
        chk("tx valid flushed", 32'h0, tx_valid_o);
        chk("irq disabled", 32'h0, irq_o);
        stall = 1'b0;
        char_link_model_inst.send(8'h77, 1'b0);
        repeat (4) @(negedge clk_i);
        chk("irq masked rx", 32'h0, irq_o);
        rd(4'h8, 32'h05, "status disabled");
        chk("taken after flush", 32'd17, char_link_model_inst.got.size());
        $display("test access done");
        summarize();
    end
endmodule
